// File: logic/ais_pkg.sv
package ais_pkg;

    // ---------------------------------------------------------------
    // register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] AIS_ADDR_OFFS_LO = 8'h85;
    localparam logic [7:0] AIS_ADDR_OFFS_HI = 8'h86;
    localparam logic [7:0] AIS_ADDR_INSEL = 8'hBB;
    localparam logic [7:0] AIS_ADDR_REFCTL = 8'hD1;

    // ---------------------------------------------------------------
    // field layouts
    // ---------------------------------------------------------------
    localparam int AIS_SEL_W = 5;
    localparam int AIS_OFFS_W = 10;
    localparam int AIS_LO_FLD_LSB = 6;
    localparam int AIS_HI_SHIFT = 2;
    localparam int AIS_REF_OVR_BIT = 4;
    localparam int AIS_REF_SRC_BIT = 3;
    localparam int AIS_REF_SENS_BIT = 2;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [4:0] AIS_SEL_RST = 5'h1F;
    localparam logic [7:0] AIS_BYTE_ZERO = 8'h00;

    // ---------------------------------------------------------------
    // select code map
    // ---------------------------------------------------------------
    localparam int AIS_P1_N = 8;
    localparam int AIS_P2_N = 8;
    localparam int AIS_P3_N = 5;
    localparam logic [4:0] AIS_SEL_P1_BASE = 5'h00;
    localparam logic [4:0] AIS_SEL_P2_BASE = 5'h08;
    localparam logic [4:0] AIS_SEL_P3_BASE = 5'h10;
    localparam logic [4:0] AIS_SEL_TEMP = 5'h1E;
    localparam logic [4:0] AIS_SEL_VDD = 5'h1F;

    // enable vector: p1 [7:0], p2 [15:8], p3 [20:16], temp [21], supply [22]
    localparam int AIS_EN_W = AIS_P1_N + AIS_P2_N + AIS_P3_N + 2;
    localparam int AIS_EN_TEMP = AIS_P1_N + AIS_P2_N + AIS_P3_N;
    localparam int AIS_EN_VDD = AIS_EN_TEMP + 1;

endpackage

// File: logic/ais_mux_if.sv
`timescale 1ns/1ps
interface ais_mux_if;
    import ais_pkg::*;
    logic [AIS_SEL_W-1:0] sel;
    logic [AIS_EN_W-1:0] en;
    modport ctl (output sel, input en);
    modport dec (input sel, output en);
endinterface

// File: logic/ais_sel_decode.sv
`timescale 1ns/1ps
module ais_sel_decode
    import ais_pkg::*;
(
    ais_mux_if.dec mux
);

    // ---------------------------------------------------------------
    // one switch per source
    // ---------------------------------------------------------------
    // port pin codes
    genvar g;
    generate
        for (g = 0; g < AIS_P1_N; g++) begin : g_p1
            assign mux.en[g] = (mux.sel == AIS_SEL_P1_BASE + 5'(g));
        end
        for (g = 0; g < AIS_P2_N; g++) begin : g_p2
            assign mux.en[AIS_P1_N+g] = (mux.sel == AIS_SEL_P2_BASE + 5'(g));
        end
        for (g = 0; g < AIS_P3_N; g++) begin : g_p3
            assign mux.en[AIS_P1_N+AIS_P2_N+g] = (mux.sel == AIS_SEL_P3_BASE + 5'(g));
        end
    endgenerate

    assign mux.en[AIS_EN_TEMP] = (mux.sel == AIS_SEL_TEMP);
    assign mux.en[AIS_EN_VDD] = (mux.sel == AIS_SEL_VDD);
    // reserved codes match no compare above, so all switches stay open

endmodule

// File: logic/ais_input_select.sv
// Notes on behaviour
// - codes 21-29 connect nothing; 30 sensor; 31 supply rail
// - input select register sits at address 0xBB
// - sensor powered only by its enable bit; software enables before converting
// - offset high byte at 0x86 holds offset bits 9:2, read/write
// - offset low byte at 0x85 holds offset bits 1:0 in bits 7:6
// - offset low bits 5:0 read zero, reset zero, ignore writes
// - offset is left-justified converter code of sensor at zero celsius
// - offset registers load the part's production-test value at reset
// - sensor enable is bit 2 of reference control at 0xD1
// - regulator override forces regulator reference regardless of select bit
`timescale 1ns/1ps
module ais_input_select
    import ais_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // special-function register access
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    // production-test offset from the trim store
    input wire logic [AIS_OFFS_W-1:0] i_factory_offset,
    // analog controls
    output logic [AIS_EN_W-1:0] o_mux_en,
    output logic o_sensor_power_on,
    output logic o_ref_use_regulator,
    output logic o_ref_use_vdd,
    output logic o_ref_use_pin
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [AIS_SEL_W-1:0] sel;
        logic [AIS_OFFS_W-1:0] offs;
        logic ovr_on;
        logic ref_src;
        logic sens_on;
        logic [AIS_EN_W-1:0] mux_en;
        logic [7:0] rdata;
        logic hit;
        logic ref_reg;
        logic ref_vdd;
        logic ref_pin;
    } ais_state_t;

    ais_state_t st_q;
    ais_state_t st_d;
    ais_mux_if mux ();

    ais_sel_decode u_dec (
        .mux(mux)
    );

    // ---------------------------------------------------------------
    // register read image
    // ---------------------------------------------------------------
    function automatic logic [7:0] ais_read(input logic [7:0] addr, input ais_state_t s);
        logic [7:0] v;
        v = AIS_BYTE_ZERO;
        // select at 0xBB; upper bits zero
        if (addr == AIS_ADDR_INSEL) begin
            v[AIS_SEL_W-1:0] = s.sel;
        end else if (addr == AIS_ADDR_OFFS_HI) begin
            v = s.offs[AIS_OFFS_W-1:AIS_HI_SHIFT];
        // low two bits at 7:6; rest zero
        end else if (addr == AIS_ADDR_OFFS_LO) begin
            v[7:AIS_LO_FLD_LSB] = s.offs[AIS_HI_SHIFT-1:0];
        end else if (addr == AIS_ADDR_REFCTL) begin
            v[AIS_REF_OVR_BIT] = s.ovr_on;
            v[AIS_REF_SRC_BIT] = s.ref_src;
            v[AIS_REF_SENS_BIT] = s.sens_on;
        end
        return v;
    endfunction

    function automatic logic ais_mapped(input logic [7:0] addr);
        return (addr == AIS_ADDR_INSEL) || (addr == AIS_ADDR_OFFS_HI)
            || (addr == AIS_ADDR_OFFS_LO) || (addr == AIS_ADDR_REFCTL);
    endfunction

    assign mux.sel = st_q.sel;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (i_sfr_wr) begin
            // select field writable; bits 7:5 dropped
            if (i_sfr_addr == AIS_ADDR_INSEL) begin
                st_d.sel = i_sfr_wdata[AIS_SEL_W-1:0];
            end else if (i_sfr_addr == AIS_ADDR_OFFS_HI) begin
                st_d.offs[AIS_OFFS_W-1:AIS_HI_SHIFT] = i_sfr_wdata;
            // low field write; bits 5:0 ignored
            end else if (i_sfr_addr == AIS_ADDR_OFFS_LO) begin
                st_d.offs[AIS_HI_SHIFT-1:0] = i_sfr_wdata[7:AIS_LO_FLD_LSB];
            end else if (i_sfr_addr == AIS_ADDR_REFCTL) begin
                st_d.ovr_on = i_sfr_wdata[AIS_REF_OVR_BIT];
                st_d.ref_src = i_sfr_wdata[AIS_REF_SRC_BIT];
                st_d.sens_on = i_sfr_wdata[AIS_REF_SENS_BIT];
            end
        end
        // read data reflects contents before this cycle's write
        st_d.rdata = ais_read(i_sfr_addr, st_q);
        st_d.hit = ais_mapped(i_sfr_addr);
        st_d.mux_en = mux.en;
        st_d.ref_reg = st_q.ovr_on;
        st_d.ref_vdd = !st_q.ovr_on && st_q.ref_src;
        st_d.ref_pin = !st_q.ovr_on && !st_q.ref_src;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            st_q <= '0;
            st_q.sel <= AIS_SEL_RST;
            // per-part trim loaded at reset; value as measured
            st_q.offs <= i_factory_offset;
            st_q.ref_pin <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_sfr_rdata = st_q.rdata;
    assign o_sfr_hit = st_q.hit;
    assign o_mux_en = st_q.mux_en;
    // sensor floats unless this bit is set
    assign o_sensor_power_on = st_q.sens_on;
    assign o_ref_use_regulator = st_q.ref_reg;
    assign o_ref_use_vdd = st_q.ref_vdd;
    assign o_ref_use_pin = st_q.ref_pin;

endmodule

// File: bench/ais_input_select_sva.sv
`timescale 1ns/1ps
module ais_input_select_sva
    import ais_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic o_sfr_hit,
    input wire logic [AIS_OFFS_W-1:0] i_factory_offset,
    input wire logic [AIS_EN_W-1:0] o_mux_en,
    input wire logic o_sensor_power_on,
    input wire logic o_ref_use_regulator,
    input wire logic o_ref_use_vdd,
    input wire logic o_ref_use_pin
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    logic mapped, ins_wr, ref_wr, sens_bit;
    assign mapped = i_sfr_addr inside {AIS_ADDR_OFFS_LO, AIS_ADDR_OFFS_HI, AIS_ADDR_INSEL,
        AIS_ADDR_REFCTL};
    assign ins_wr = i_sfr_wr && i_sfr_addr == AIS_ADDR_INSEL;
    assign ref_wr = i_sfr_wr && i_sfr_addr == AIS_ADDR_REFCTL;
    assign sens_bit = i_sfr_wdata[AIS_REF_SENS_BIT];
    // a second write right behind would move the target, so demand a quiet cycle
    sequence s_temp_sel;
        ins_wr && i_sfr_wdata[4:0] == AIS_SEL_TEMP ##1 !ins_wr;
    endsequence
    sequence s_resv_sel;
        ins_wr && i_sfr_wdata[4:0] inside {[21:29]} ##1 !ins_wr;
    endsequence
    sequence s_ovr_set;
        ref_wr && i_sfr_wdata[AIS_REF_OVR_BIT] ##1 !ref_wr;
    endsequence
    a_mux_exclusive: assert property ($onehot0(o_mux_en))
        else $error("mux enables not exclusive");
    a_ref_exclusive: assert property ($onehot({o_ref_use_regulator, o_ref_use_vdd,
        o_ref_use_pin})) else $error("reference choice not one-hot");
    a_unmapped_zero: assert property (!mapped |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_mapped_hit: assert property (mapped |=> o_sfr_hit)
        else $error("mapped read without hit");
    a_insel_upper: assert property (i_sfr_addr == AIS_ADDR_INSEL |=> o_sfr_rdata[7:5] == 3'h0)
        else $error("select upper bits not zero");
    a_lo_unused: assert property (i_sfr_addr == AIS_ADDR_OFFS_LO |=> o_sfr_rdata[5:0] == 6'h00)
        else $error("offset low unused bits not zero");
    a_temp_route: assert property (s_temp_sel |=> o_mux_en[AIS_EN_TEMP])
        else $error("sensor code did not route sensor");
    a_resv_none: assert property (s_resv_sel |=> o_mux_en == '0)
        else $error("reserved code enabled a switch");
    a_sensor_follow: assert property (ref_wr |=> o_sensor_power_on == $past(sens_bit))
        else $error("sensor power does not follow write");
    a_ovr_forces: assert property (s_ovr_set |=> o_ref_use_regulator)
        else $error("override did not force regulator");
endmodule
bind ais_input_select ais_input_select_sva u_sva (.*);

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
    import ais_pkg::*;
    logic i_mclk = 0, i_nrst = 0, i_sfr_wr = 0;
    logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, d;
    logic [AIS_OFFS_W-1:0] i_factory_offset = 0;
    logic [7:0] o_sfr_rdata;
    logic o_sfr_hit, o_sensor_power_on, o_ref_use_regulator, o_ref_use_vdd, o_ref_use_pin;
    logic [AIS_EN_W-1:0] o_mux_en;
    int err_count = 0, checked = 0;
    always #2.5 i_mclk = ~i_mclk;
    ais_input_select uut (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_sfr_addr(i_sfr_addr),
        .i_sfr_wr(i_sfr_wr),
        .i_sfr_wdata(i_sfr_wdata),
        .o_sfr_rdata(o_sfr_rdata),
        .o_sfr_hit(o_sfr_hit),
        .i_factory_offset(i_factory_offset),
        .o_mux_en(o_mux_en),
        .o_sensor_power_on(o_sensor_power_on),
        .o_ref_use_regulator(o_ref_use_regulator),
        .o_ref_use_vdd(o_ref_use_vdd),
        .o_ref_use_pin(o_ref_use_pin)
    );
    function automatic logic [AIS_EN_W-1:0] exp_en(input logic [4:0] c);
        exp_en = '0;
        if (c <= 5'h14) exp_en[c] = 1'b1;
        else if (c == AIS_SEL_TEMP) exp_en[AIS_EN_TEMP] = 1'b1;
        else if (c == AIS_SEL_VDD) exp_en[AIS_EN_VDD] = 1'b1;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_mclk);
        i_sfr_addr <= a;
        i_sfr_wdata <= v;
        i_sfr_wr <= 1'b1;
        @(posedge i_mclk);
        i_sfr_wr <= 1'b0;
    endtask
    // read image lands one edge after the address is presented
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
        @(posedge i_mclk);
        i_sfr_addr <= a;
        @(posedge i_mclk);
        #1;
        chk(o_sfr_rdata, e);
        chk(o_sfr_hit, h);
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        i_factory_offset <= 10'($urandom(43881));
        repeat (5) @(posedge i_mclk);
        i_nrst <= 1'b1;
        // software reads back the trim to correct raw sensor codes
        rd(AIS_ADDR_OFFS_HI, i_factory_offset[9:2], 1'b1);
        rd(AIS_ADDR_OFFS_LO, {i_factory_offset[1:0], 6'h00}, 1'b1);
        rd(AIS_ADDR_INSEL, {3'h0, AIS_SEL_RST}, 1'b1);
        chk(o_mux_en, exp_en(AIS_SEL_RST));
        rd(AIS_ADDR_REFCTL, AIS_BYTE_ZERO, 1'b1);
        chk({o_ref_use_regulator, o_ref_use_vdd, o_ref_use_pin}, 3'b001);
        for (int c = 0; c < 32; c++) begin
            d = {3'($urandom), 5'(c)};
            wr(AIS_ADDR_INSEL, d);
            rd(AIS_ADDR_INSEL, {3'h0, d[4:0]}, 1'b1);
            chk(o_mux_en, exp_en(d[4:0]));
        end
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h08 : (i == 2) ? 8'h00 : 8'($urandom);
            wr(AIS_ADDR_REFCTL, d);
            rd(AIS_ADDR_REFCTL, d & 8'h1C, 1'b1);
            chk(o_sensor_power_on, d[2]);
            chk({o_ref_use_regulator, o_ref_use_vdd, o_ref_use_pin},
                d[4] ? 3'b100 : (d[3] ? 3'b010 : 3'b001));
        end
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            wr(AIS_ADDR_OFFS_HI, d);
            rd(AIS_ADDR_OFFS_HI, d, 1'b1);
            wr(AIS_ADDR_OFFS_LO, ~d);
            rd(AIS_ADDR_OFFS_LO, ~d & 8'hC0, 1'b1);
        end
        wr(8'h84, 8'hFF);
        rd(8'h84, AIS_BYTE_ZERO, 1'b0);
        wr(8'hBA, 8'h00);
        rd(AIS_ADDR_INSEL, 8'h1F, 1'b1);
        end_of_test();
    end
    initial begin
        #20000;
        err_count++;
        end_of_test();
    end
endmodule
